// ### design/floppy_drive_control_sequencer.sv
// drive-side control sequencer: select, head load, spindle, stepping
//
// Overview of operation
// - selection loads head and lights front LED
// - drive adds second stepper increment per track
// - head loaded and settled within 75 ms
// - single-track move completes within 40 ms
// - spindle 300 RPM, one index per revolution
// - FM flux data at 125 kbit/s
// - direction latched at step trailing edge
// - direction high steps outward, low inward
// - select, spindle run, step, record enable and write flux inputs are active low; direction and sensor inputs are not
`timescale 1ns/10ps
module floppy_drive_control_sequencer #(
   parameter int HEAD_LOAD_CYCLES = floppy_pkg::HEAD_LOAD_CYCLES,
   parameter int TRACK_STEP_CYCLES = floppy_pkg::TRACK_STEP_CYCLES,
   parameter int MOTOR_START_CYCLES = floppy_pkg::MOTOR_START_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic unit_select_n,
   input wire logic spindle_run_n,
   input wire logic seek_direction,
   input wire logic step_n,
   input wire logic record_enable_n,
   input wire logic write_flux_pulses_n,
   input wire logic track0_sensor,
   input wire logic index_sensor,
   input wire logic read_flux_sensor,
   output logic home_track_flag_n,
   output logic index_n,
   output logic read_data_n,
   output logic head_load,
   output logic front_led,
   output logic head_settled,
   output logic spindle_motor_on,
   output logic spindle_at_speed,
   output logic [3:0] stepper_coils,
   output logic step_busy,
   output logic write_current_enable,
   output logic write_flux_toggle
);
   import floppy_pkg::*;
   localparam int HW = $clog2(HEAD_LOAD_CYCLES + 1);
   localparam int MW = $clog2(MOTOR_START_CYCLES + 1);
   localparam int HALF_STEP = TRACK_STEP_CYCLES / INCREMENTS_PER_TRACK;
   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [NUM_PINS-1:0] sync1;
      logic [NUM_PINS-1:0] sync2;
      logic step_prev;
      logic wflux_prev;
      logic start;
      logic outward;
      logic [HW-1:0] head_cnt;
      logic [MW-1:0] motor_cnt;
      logic home_n;
      logic idx_n;
      logic rdata_n;
      logic load;
      logic settled;
      logic motor;
      logic at_speed;
      logic [3:0] coils;
      logic wr_en;
      logic flux;
   } seq_s;
   seq_s cur;
   seq_s next_cur;
   step_if st ();
   logic [NUM_PINS-1:0] pins;
   logic sel;
   logic step_rise;
   logic wflux_fall;
   logic head_full;
   logic motor_full;
   logic run_active;
   logic rec_active;
   // ***********************************************************
   // reset value: pins inactive, head unloaded, coil one
   // ***********************************************************
   localparam seq_s SEQ_RESET = '{
      sync1: PIN_RESET,
      sync2: PIN_RESET,
      step_prev: 1'b1,
      wflux_prev: 1'b1,
      start: 1'b0,
      outward: 1'b0,
      head_cnt: '0,
      motor_cnt: '0,
      home_n: 1'b1,
      idx_n: 1'b1,
      rdata_n: 1'b1,
      load: 1'b0,
      settled: 1'b0,
      motor: 1'b0,
      at_speed: 1'b0,
      coils: 4'h1,
      wr_en: 1'b0,
      flux: 1'b0};
   // ***********************************************************
   // pin inputs, bit order of the synchroniser
   // ***********************************************************
   assign pins = {read_flux_sensor,
                  index_sensor,
                  track0_sensor,
                  write_flux_pulses_n,
                  record_enable_n,
                  step_n,
                  seek_direction,
                  spindle_run_n,
                  unit_select_n};
   // ***********************************************************
   // decoded synchronised inputs
   // ***********************************************************
   assign sel = !cur.sync2[PIN_SELECT_N];
   assign run_active = !cur.sync2[PIN_SPINDLE_N];
   assign rec_active = !cur.sync2[PIN_RECORD_N];
   // trailing edge of the active-low step pulse
   assign step_rise = !cur.step_prev && cur.sync2[PIN_STEP_N];
   assign wflux_fall = cur.wflux_prev && !cur.sync2[PIN_WFLUX_N];
   assign head_full = (cur.head_cnt == HW'(HEAD_LOAD_CYCLES));
   assign motor_full = (cur.motor_cnt == MW'(MOTOR_START_CYCLES));
   // ***********************************************************
   // stepper increments
   // ***********************************************************
   stepper_increment_gen #(
      .GAP_CYCLES(HALF_STEP),
      .SETTLE_CYCLES(TRACK_STEP_CYCLES - HALF_STEP)
   ) u_stepper (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .st(st)
   );
   assign st.start = cur.start;
   assign st.outward = cur.outward;
   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      next_cur = cur;
      // ***********************************************************
      // synchroniser and edge history
      // ***********************************************************
      next_cur.sync1 = pins;
      next_cur.sync2 = cur.sync1;
      next_cur.step_prev = cur.sync2[PIN_STEP_N];
      next_cur.wflux_prev = cur.sync2[PIN_WFLUX_N];
      // ***********************************************************
      // step start, ignored while unselected or busy
      // ***********************************************************
      next_cur.start = sel && step_rise && !st.busy;
      next_cur.outward = cur.sync2[PIN_DIR];
      // ***********************************************************
      // head load and settle timing
      // ***********************************************************
      next_cur.load = sel;
      if (!sel) begin
         next_cur.head_cnt = '0;
      end else if (!head_full) begin
         next_cur.head_cnt = cur.head_cnt + 1'b1;
      end
      next_cur.settled = sel && head_full;
      // ***********************************************************
      // spindle motor follows the run line directly
      // ***********************************************************
      next_cur.motor = run_active;
      if (!run_active) begin
         next_cur.motor_cnt = '0;
      end else if (!motor_full) begin
         next_cur.motor_cnt = cur.motor_cnt + 1'b1;
      end
      next_cur.at_speed = run_active && motor_full;
      // ***********************************************************
      // status outputs gated by selection
      // ***********************************************************
      next_cur.home_n = !(sel && cur.sync2[PIN_TRACK0]);
      next_cur.idx_n = !(sel && cur.sync2[PIN_INDEX]);
      next_cur.rdata_n = !(sel && cur.sync2[PIN_RFLUX]);
      // ***********************************************************
      // one-hot coil drive from stepper phase
      // ***********************************************************
      next_cur.coils = 4'h1 << st.phase;
      // ***********************************************************
      // write path: no writing while the head moves
      // ***********************************************************
      next_cur.wr_en = sel && rec_active && !st.busy;
      if (cur.wr_en && wflux_fall) begin
         next_cur.flux = !cur.flux;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cur <= SEQ_RESET;
      end else begin
         cur <= next_cur;
      end
   end
   // ***********************************************************
   // outputs
   // ***********************************************************
   assign home_track_flag_n = cur.home_n;
   assign index_n = cur.idx_n;
   assign read_data_n = cur.rdata_n;
   assign head_load = cur.load;
   assign front_led = cur.load;
   assign head_settled = cur.settled;
   assign spindle_motor_on = cur.motor;
   assign spindle_at_speed = cur.at_speed;
   assign stepper_coils = cur.coils;
   assign step_busy = st.busy;
   assign write_current_enable = cur.wr_en;
   assign write_flux_toggle = cur.flux;
endmodule : floppy_drive_control_sequencer

// ### design/floppy_pkg.sv
// constants, pin positions and types of the drive control sequencer
package floppy_pkg;
   // ***********************************************************
   // clock and timing
   // ***********************************************************
   localparam int CLK_KHZ = 10000;
   localparam int HEAD_LOAD_MS = 75;
   localparam int TRACK_STEP_MS = 40;
   localparam int MOTOR_START_MS = 1000;
   localparam int SPIN_RPM = 300;
   localparam int REV_MS = 60000 / SPIN_RPM;
   localparam int BIT_RATE_BPS = 125000;
   localparam int BIT_CELL_NS = 1000000000 / BIT_RATE_BPS;
   localparam int CLK_PERIOD_NS = 1000000 / CLK_KHZ;
   localparam int BIT_CELL_CYCLES = BIT_CELL_NS / CLK_PERIOD_NS;
   localparam int HEAD_LOAD_CYCLES = HEAD_LOAD_MS * CLK_KHZ;
   localparam int TRACK_STEP_CYCLES = TRACK_STEP_MS * CLK_KHZ;
   localparam int MOTOR_START_CYCLES = MOTOR_START_MS * CLK_KHZ;
   localparam int INCREMENTS_PER_TRACK = 2;
   // ***********************************************************
   // positions of the synchronised pin inputs
   // ***********************************************************
   localparam int NUM_PINS = 9;
   localparam int PIN_SELECT_N = 0;
   localparam int PIN_SPINDLE_N = 1;
   localparam int PIN_DIR = 2;
   localparam int PIN_STEP_N = 3;
   localparam int PIN_RECORD_N = 4;
   localparam int PIN_WFLUX_N = 5;
   localparam int PIN_TRACK0 = 6;
   localparam int PIN_INDEX = 7;
   localparam int PIN_RFLUX = 8;
   localparam logic [NUM_PINS-1:0] PIN_RESET = 9'h03F;
   // ***********************************************************
   // stepper sequencer states
   // ***********************************************************
   typedef enum logic [1:0] {
      STEP_IDLE = 2'b00,
      STEP_GAP = 2'b01,
      STEP_SETTLE = 2'b11
   } step_state_e;
endpackage : floppy_pkg

// ### design/step_if.sv
// link between the control sequencer and the stepper increment logic
`timescale 1ns/10ps
interface step_if;
   logic start;
   logic outward;
   logic busy;
   logic [1:0] phase;
   modport seq (output start, output outward, input busy, input phase);
   modport motor (input start, input outward, output busy, output phase);
endinterface : step_if

// ### design/stepper_increment_gen.sv
// two stepper increments per host step, then settle
`timescale 1ns/10ps
module stepper_increment_gen #(
   parameter int GAP_CYCLES = floppy_pkg::TRACK_STEP_CYCLES / 2,
   parameter int SETTLE_CYCLES = floppy_pkg::TRACK_STEP_CYCLES / 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   step_if.motor st
);
   import floppy_pkg::*;
   localparam int CW = $clog2(GAP_CYCLES + SETTLE_CYCLES + 1);
   typedef struct packed {
      step_state_e state;
      logic outward;
      logic [1:0] phase;
      logic [CW-1:0] cnt;
   } inc_s;
   inc_s cur;
   inc_s nxt;
   function automatic logic [1:0] advance(input logic [1:0] p,
                                          input logic out);
      advance = out ? p - 2'h1 : p + 2'h1;
   endfunction : advance
   always_comb begin
      nxt = cur;
      case (cur.state)
         STEP_IDLE: begin
            if (st.start) begin
               nxt.outward = st.outward;
               nxt.phase = advance(cur.phase, st.outward);
               nxt.cnt = CW'(GAP_CYCLES - 1);
               nxt.state = STEP_GAP;
            end
         end
         STEP_GAP: begin
            if (cur.cnt == '0) begin
               nxt.phase = advance(cur.phase, cur.outward);
               nxt.cnt = CW'(SETTLE_CYCLES - 1);
               nxt.state = STEP_SETTLE;
            end else begin
               nxt.cnt = cur.cnt - 1'b1;
            end
         end
         STEP_SETTLE: begin
            if (cur.cnt == '0) begin
               nxt.state = STEP_IDLE;
            end else begin
               nxt.cnt = cur.cnt - 1'b1;
            end
         end
         default: begin
            nxt.state = STEP_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cur <= '{STEP_IDLE, 1'b0, 2'h0, '0};
      end else begin
         cur <= nxt;
      end
   end
   assign st.busy = (cur.state != STEP_IDLE);
   assign st.phase = cur.phase;
endmodule : stepper_increment_gen

// ### verif/floppy_sva.sv
// assertions on the drive control sequencer ports
`timescale 1ns/10ps
module floppy_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic unit_select_n,
   input wire logic spindle_run_n,
   input wire logic home_track_flag_n,
   input wire logic index_n,
   input wire logic head_load,
   input wire logic front_led,
   input wire logic head_settled,
   input wire logic spindle_motor_on,
   input wire logic spindle_at_speed,
   input wire logic [3:0] stepper_coils,
   input wire logic step_busy,
   input wire logic write_current_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_go; $rose(step_busy); endsequence
   sequence s_hold; step_busy [*8]; endsequence
   AST_LED: assert property (front_led == head_load)
      else $error("led differs from head load");
   AST_SEL: assert property ($fell(unit_select_n) |-> ##3 head_load)
      else $error("head not loaded");
   AST_GATE: assert property (!head_load |-> home_track_flag_n && index_n)
      else $error("status active unselected");
   AST_SETTLE: assert property ($rose(head_load) |-> !head_settled [*8])
      else $error("settled too soon");
   AST_SPIN: assert property ($fell(spindle_run_n) |->
      ##3 spindle_motor_on && !spindle_at_speed)
      else $error("spindle start wrong");
   AST_HOT: assert property ($onehot(stepper_coils))
      else $error("coils not one hot");
   AST_COIL: assert property (!$stable(stepper_coils) |-> $past(step_busy))
      else $error("coil moved while idle");
   AST_BUSY: assert property (s_go |-> s_hold)
      else $error("step too short");
   AST_END: assert property (s_go |-> ##[1:40] !step_busy)
      else $error("step too long");
   AST_WR: assert property (step_busy ##1 step_busy |-> !write_current_enable)
      else $error("write during step");
endmodule : floppy_sva
bind floppy_drive_control_sequencer floppy_sva floppy_sva_inst (.ref_clk,
   .rst_n, .unit_select_n, .spindle_run_n, .home_track_flag_n, .index_n,
   .head_load, .front_led, .head_settled, .spindle_motor_on,
   .spindle_at_speed, .stepper_coils, .step_busy, .write_current_enable);

// ### verif/host_step_model.sv
// host side step pulse generator
`timescale 1ns/10ps
module host_step_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic dir,
   input wire logic rec,
   output logic seek_direction,
   output logic step_n,
   output logic record_enable_n
);
   int cnt;
   initial begin
      cnt = 0;
      seek_direction = 1'h1;
      step_n = 1'h1;
      record_enable_n = 1'h1;
   end
   always @(negedge ref_clk) begin
      if (go && cnt == 0) begin
         seek_direction <= dir;
         cnt <= 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      step_n <= !(cnt inside {[2:4]});
      record_enable_n <= !(rec && cnt == 0);
   end
endmodule : host_step_model

// ### verif/floppy_drive_control_sequencer_tb_top.sv
// testbench of the drive control sequencer
`timescale 1ns/10ps
module floppy_drive_control_sequencer_tb_top;
   // ********
   // signals
   // ********
   logic ref_clk, rst_n, unit_select_n, spindle_run_n, track0_sensor;
   logic index_sensor, go, dir, seek_direction, step_n, record_enable_n;
   logic home_track_flag_n, index_n, head_load, front_led, head_settled;
   logic spindle_motor_on, spindle_at_speed, step_busy, wr_en;
   logic rec, write_flux_pulses_n, read_flux_sensor, read_data_n;
   logic write_flux_toggle;
   logic [3:0] stepper_coils;
   int errors, n_tests;
   floppy_drive_control_sequencer #(.HEAD_LOAD_CYCLES(20),
      .TRACK_STEP_CYCLES(20), .MOTOR_START_CYCLES(30))
   floppy_drive_control_sequencer_inst (.ref_clk, .rst_n, .unit_select_n,
      .spindle_run_n, .seek_direction, .step_n, .record_enable_n,
      .write_flux_pulses_n, .track0_sensor, .index_sensor,
      .read_flux_sensor, .home_track_flag_n, .index_n,
      .read_data_n, .head_load, .front_led, .head_settled,
      .spindle_motor_on, .spindle_at_speed, .stepper_coils, .step_busy,
      .write_current_enable(wr_en), .write_flux_toggle);
   host_step_model host_step_model_inst (.ref_clk, .go, .dir, .rec,
      .seek_direction, .step_n, .record_enable_n);
   task give_verdict;
      if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'h1) begin
         errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   task tmo(input logic hit);
      if (hit) begin
         chk(1'h0, "timeout");
         give_verdict;
      end
   endtask : tmo
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task t_select;
      int k;
      unit_select_n = 1'h0;
      cyc(4);
      chk(head_load === 1'h1 && front_led === 1'h1, "no load");
      k = 0;
      while (head_settled !== 1'h1 && k < 40) begin cyc(1); k++; end
      tmo(k == 40);
      chk(k >= 19 && k <= 21, "settle time");
   endtask : t_select
   task t_spin;
      int k;
      spindle_run_n = 1'h0;
      cyc(4);
      chk(spindle_motor_on === 1'h1, "motor off");
      k = 0;
      while (spindle_at_speed !== 1'h1 && k < 50) begin cyc(1); k++; end
      tmo(k == 50);
      chk(k >= 29 && k <= 31, "speed time");
      spindle_run_n = 1'h1;
      cyc(4);
      chk(spindle_motor_on === 1'h0, "motor on");
      chk(spindle_at_speed === 1'h0, "speed kept");
   endtask : t_spin
   task t_status;
      track0_sensor = 1'h1;
      index_sensor = 1'h1;
      cyc(4);
      chk(home_track_flag_n === 1'h0 && index_n === 1'h0, "flags");
      unit_select_n = 1'h1;
      cyc(4);
      chk(home_track_flag_n === 1'h1 && index_n === 1'h1, "gate");
      chk(head_load === 1'h0 && front_led === 1'h0, "unload");
      unit_select_n = 1'h0;
      track0_sensor = 1'h0;
      index_sensor = 1'h0;
      cyc(4);
   endtask : t_status
   task t_step(input logic d, input logic twice);
      logic [3:0] c, e;
      int n, k;
      c = stepper_coils;
      n = 0;
      k = 0;
      dir = d;
      go <= 1'h1;
      cyc(1);
      go <= 1'h0;
      while (step_n === 1'h1 && k < 10) begin cyc(1); k++; end
      tmo(k == 10);
      while (step_n !== 1'h1 && k < 20) begin
         chk(stepper_coils === c, "early move");
         cyc(1);
         k++;
      end
      if (twice) begin
         cyc(8);
         go <= 1'h1;
         cyc(1);
         go <= 1'h0;
      end
      for (k = 0; k < 50; k++) begin
         if (stepper_coils !== c) begin
            e = d ? {c[0], c[3:1]} : {c[2:0], c[3]};
            chk(stepper_coils === e, "coil order");
            c = stepper_coils;
            n++;
         end
         cyc(1);
      end
      chk(n == 2, "increment count");
      chk(step_busy === 1'h0, "busy stuck");
   endtask : t_step
   task step_once(input logic d);
      int k;
      dir = d;
      go <= 1'h1;
      cyc(1);
      go <= 1'h0;
      k = 0;
      while (step_busy !== 1'h1 && k < 20) begin cyc(1); k++; end
      tmo(k == 20);
      while (step_busy !== 1'h0 && k < 80) begin cyc(1); k++; end
      tmo(k == 80);
   endtask : step_once
   task t_recal;
      int pos, n;
      pos = 3;
      for (n = 0; n < 58 && home_track_flag_n !== 1'h0;
           n++) begin
         step_once(1'h1);
         pos--;
         track0_sensor = (pos == 0);
         cyc(4);
      end
      chk(n == 3 && home_track_flag_n === 1'h0, "recalibrate");
      track0_sensor = 1'h0;
      cyc(4);
   endtask : t_recal
   task t_rw;
      logic f;
      int i;
      read_flux_sensor = 1'h1;
      cyc(4);
      chk(read_data_n === 1'h0, "read data");
      read_flux_sensor = 1'h0;
      rec = 1'h1;
      cyc(4);
      chk(read_data_n === 1'h1 && wr_en === 1'h1, "write gate");
      f = write_flux_toggle;
      for (i = 0; i < 2; i++) begin
         write_flux_pulses_n = 1'h0;
         cyc(2);
         write_flux_pulses_n = 1'h1;
         cyc(floppy_pkg::BIT_CELL_CYCLES - 2);
         f = !f;
         chk(write_flux_toggle === f, "flux toggle");
      end
      rec = 1'h0;
      cyc(4);
      chk(wr_en === 1'h0, "write gate off");
   endtask : t_rw
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      {unit_select_n, spindle_run_n, dir} = 3'h7;
      {rec, write_flux_pulses_n, read_flux_sensor} = 3'h2;
      {rst_n, track0_sensor, index_sensor, go} = 4'h0;
      errors = 0;
      n_tests = 0;
      cyc(4);
      rst_n = 1'h1;
      cyc(10);
      t_select;
      t_spin;
      t_status;
      t_rw;
      t_recal;
      t_step(1'h1, 1'h0);
      t_step(1'h0, 1'h1);
      give_verdict;
   end
endmodule : floppy_drive_control_sequencer_tb_top
